// ===== design/prcd_top.sv
// PLL ratio configuration decoder: captures straps and config word at reset
// ==========================================================
// How it works
// - SVCO code 00/01/10 gives divide 4/8/2
// - Multiplier 0000 is x16, 0001 reserved, else binary
// - Divide strap high: bus clock is multiplier ratio
// - Host uses host reference, agent uses agent reference
// - Seven-bit field sets processor to bus ratio
// - Mode bits 0000 bypass the processor PLL
// - Mode 0001: bit6 picks 1:1 or 1.5:1, bits0-1 VCO
module prcd_top
  import prcd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire prcd_pkg::prcd_cfg_t cfg_in,
  output prcd_pkg::prcd_dec_t dec_out,
  output logic dec_valid
);

  // ==========================================================
  // Input synchronisation
  prcd_cfg_t cfg_sync;
  prcd_cfg_t cfg_q;
  logic [1:0] wait_q;
  logic captured_q;

  prcd_sync #(
    .WIDTH($bits(prcd_cfg_t))
  ) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in(cfg_in),
    .sync_out(cfg_sync)
  );

  // ==========================================================
  // One-shot capture
  // Wait for the synchroniser to fill with live pin values first
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      wait_q <= '0;
    else if (wait_q != CAPTURE_WAIT)
      wait_q <= wait_q + 2'h1;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_q <= '0;
      captured_q <= 1'b0;
    end
    else if (!captured_q && wait_q == CAPTURE_WAIT)
    begin
      cfg_q <= cfg_sync;
      captured_q <= 1'b1;
    end
  end

  // ==========================================================
  // Decode
  prcd_dec_t dec_d;
  logic [3:0] core_mode_bits;
  logic [1:0] core_vdiv_bits;
  logic core_half;

  assign core_mode_bits = cfg_q.processor_pll_ratio[CORE_MODE_LSB +: 4];
  assign core_vdiv_bits = cfg_q.processor_pll_ratio[CORE_VDIV_LSB +: 2];
  assign core_half = cfg_q.processor_pll_ratio[CORE_HALF_BIT];

  always_comb
  begin
    dec_d = '0;
    // Agent mode: host reference is held low, so select agent input
    dec_d.ref_sel_agent = !cfg_q.host_mode;

    unique case (cfg_q.system_vco_divider)
      SVCO_DIV4_CODE: dec_d.svco_divide = DIV_BY_4;
      SVCO_DIV8_CODE: dec_d.svco_divide = DIV_BY_8;
      SVCO_DIV2_CODE: dec_d.svco_divide = DIV_BY_2;
      default:
      begin
        // Reserved code; flagged rather than guessed
        dec_d.svco_divide = DIV_NONE;
        dec_d.cfg_error = 1'b1;
      end
    endcase

    if (cfg_q.system_pll_multiplier == MULT_X16_CODE)
      dec_d.csb_multiplier = MULT_X16_VAL;
    else if (cfg_q.system_pll_multiplier == MULT_RSVD_CODE)
    begin
      dec_d.csb_multiplier = RATIO_NONE;
      dec_d.cfg_error = 1'b1;
    end
    else
      dec_d.csb_multiplier = {1'b0, cfg_q.system_pll_multiplier};

    // Divide strap low in host mode gives no defined ratio here
    if (cfg_q.host_mode && !cfg_q.input_clock_divide_strap)
      dec_d.cfg_error = 1'b1;
    // Agent mode with strap high breaks the board contract
    if (!cfg_q.host_mode && cfg_q.input_clock_divide_strap)
      dec_d.cfg_error = 1'b1;

    if (core_mode_bits == CORE_BYPASS_CODE)
    begin
      dec_d.core_mode = PRCD_CORE_BYPASS;
      dec_d.core_pll_enable = 1'b0;
      dec_d.core_vco_divide = DIV_NONE;
    end
    else if (core_mode_bits == CORE_ACTIVE_CODE)
    begin
      dec_d.core_pll_enable = 1'b1;
      dec_d.core_mode = core_half ? PRCD_CORE_3TO2 : PRCD_CORE_1TO1;
      unique case (core_vdiv_bits)
        CORE_VDIV2_CODE: dec_d.core_vco_divide = DIV_BY_2;
        CORE_VDIV4_CODE: dec_d.core_vco_divide = DIV_BY_4;
        CORE_VDIV8_CODE: dec_d.core_vco_divide = DIV_BY_8;
        default:
        begin
          dec_d.core_vco_divide = DIV_BY_8;
          // Code 11 defined only at 1:1
          if (core_half)
          begin
            dec_d.core_mode = PRCD_CORE_RSVD;
            dec_d.cfg_error = 1'b1;
          end
        end
      endcase
    end
    else
    begin
      dec_d.core_mode = PRCD_CORE_RSVD;
      dec_d.core_pll_enable = 1'b0;
      dec_d.core_vco_divide = DIV_NONE;
      dec_d.cfg_error = 1'b1;
    end
  end

  // ==========================================================
  // Registered outputs, frozen after capture
  logic loaded_q;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dec_out <= '0;
      dec_valid <= 1'b0;
      loaded_q <= 1'b0;
    end
    else if (captured_q && !loaded_q)
    begin
      dec_out <= dec_d;
      dec_valid <= 1'b1;
      loaded_q <= 1'b1;
    end
  end

endmodule : prcd_top

// ===== design/prcd_pkg.sv
// Package for the PLL ratio configuration decoder
package prcd_pkg;

  // ==========================================================
  // Field widths
  localparam int unsigned MULT_W = 4;
  localparam int unsigned VDIV_W = 2;
  localparam int unsigned CORE_W = 7;
  localparam int unsigned RATIO_W = 5;

  // ==========================================================
  // System VCO divider codes and values
  localparam logic [VDIV_W-1:0] SVCO_DIV4_CODE = 2'h0;
  localparam logic [VDIV_W-1:0] SVCO_DIV8_CODE = 2'h1;
  localparam logic [VDIV_W-1:0] SVCO_DIV2_CODE = 2'h2;
  localparam logic [3:0] DIV_BY_2 = 4'h2;
  localparam logic [3:0] DIV_BY_4 = 4'h4;
  localparam logic [3:0] DIV_BY_8 = 4'h8;
  localparam logic [3:0] DIV_NONE = 4'h0;

  // ==========================================================
  // System PLL multiplier codes
  localparam logic [MULT_W-1:0] MULT_X16_CODE = 4'h0;
  localparam logic [MULT_W-1:0] MULT_RSVD_CODE = 4'h1;
  localparam logic [RATIO_W-1:0] MULT_X16_VAL = 5'h10;
  localparam logic [RATIO_W-1:0] RATIO_NONE = 5'h00;

  // ==========================================================
  // Processor PLL field layout and codes
  localparam int unsigned CORE_VDIV_LSB = 0;
  localparam int unsigned CORE_MODE_LSB = 2;
  localparam int unsigned CORE_HALF_BIT = 6;
  localparam logic [3:0] CORE_BYPASS_CODE = 4'h0;
  localparam logic [3:0] CORE_ACTIVE_CODE = 4'h1;
  localparam logic [1:0] CORE_VDIV2_CODE = 2'h0;
  localparam logic [1:0] CORE_VDIV4_CODE = 2'h1;
  localparam logic [1:0] CORE_VDIV8_CODE = 2'h2;

  // Capture delay after reset release, in cycles
  localparam logic [1:0] CAPTURE_WAIT = 2'h2;

  typedef enum logic [1:0] {
    PRCD_CORE_BYPASS,
    PRCD_CORE_1TO1,
    PRCD_CORE_3TO2,
    PRCD_CORE_RSVD
  } prcd_core_mode_t;

  typedef struct packed {
    logic host_mode;
    logic input_clock_divide_strap;
    logic [MULT_W-1:0] system_pll_multiplier;
    logic [VDIV_W-1:0] system_vco_divider;
    logic [CORE_W-1:0] processor_pll_ratio;
  } prcd_cfg_t;

  typedef struct packed {
    logic ref_sel_agent;
    logic [RATIO_W-1:0] csb_multiplier;
    logic [3:0] svco_divide;
    prcd_core_mode_t core_mode;
    logic [3:0] core_vco_divide;
    logic core_pll_enable;
    logic cfg_error;
  } prcd_dec_t;

endpackage : prcd_pkg

// ===== design/prcd_sync.sv
// Two-flop synchroniser, one per configuration bit
module prcd_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : prcd_sync

// ===== bench/prcd_sva.sv
// Checker for the PLL ratio configuration decoder
module prcd_sva
  import prcd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire prcd_pkg::prcd_cfg_t cfg_in,
  input wire prcd_pkg::prcd_dec_t dec_out,
  input wire logic dec_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire [3:0] m = cfg_in.system_pll_multiplier;
  wire [1:0] v = cfg_in.system_vco_divider;
  wire [6:0] r = cfg_in.processor_pll_ratio;
  wire go = dec_valid && !dec_out.cfg_error;
  // ==========================================================
  // Capture timing and hold
  a_valid_late: assert property ($rose(rstn) |-> !dec_valid [*4] ##1 dec_valid)
    else $error("valid latency wrong");
  a_valid_hold: assert property (dec_valid |=> dec_valid)
    else $error("valid dropped");
  a_out_frozen: assert property (dec_valid && $past(dec_valid) |-> $stable(dec_out))
    else $error("decode changed");
  // ==========================================================
  // Field decode, checked as the decode lands; PLL enable on every error-free valid cycle
  a_svco_map: assert property ($rose(dec_valid) |-> dec_out.svco_divide ==
    (v == 2'h0 ? 4'h4 : v == 2'h1 ? 4'h8 : v == 2'h2 ? 4'h2 : 4'h0))
    else $error("vco divider wrong");
  a_mult_map: assert property ($rose(dec_valid) |-> dec_out.csb_multiplier ==
    (m == 4'h0 ? 5'h10 : m == 4'h1 ? 5'h00 : {1'b0, m}))
    else $error("multiplier wrong");
  a_ref_pick: assert property ($rose(dec_valid) |->
    dec_out.ref_sel_agent == !cfg_in.host_mode)
    else $error("reference wrong");
  a_core_bypass: assert property ($rose(dec_valid) && r[5:2] == 4'h0 |->
    dec_out.core_mode == PRCD_CORE_BYPASS && !dec_out.core_pll_enable)
    else $error("bypass wrong");
  a_core_ratio: assert property ($rose(dec_valid) && r[5:2] == 4'h1 && r != 7'h47 |->
    dec_out.core_mode == (r[6] ? PRCD_CORE_3TO2 : PRCD_CORE_1TO1))
    else $error("core ratio wrong");
  a_core_vdiv: assert property ($rose(dec_valid) && r[5:2] == 4'h1 && r != 7'h47 |->
    dec_out.core_vco_divide == (r[1:0] == 2'h0 ? 4'h2 : r[1:0] == 2'h1 ? 4'h4 : 4'h8))
    else $error("core vco wrong");
  // Reserved codes and strap misuse must raise the error flag
  a_error_flag: assert property ($rose(dec_valid) |-> dec_out.cfg_error ==
    (v == 2'h3 || m == 4'h1 || cfg_in.host_mode != cfg_in.input_clock_divide_strap ||
    r[5:2] > 4'h1 || r == 7'h47))
    else $error("error flag wrong");
  a_pll_enable: assert property (go |->
    dec_out.core_pll_enable == (dec_out.core_mode != PRCD_CORE_BYPASS))
    else $error("pll enable wrong");
endmodule : prcd_sva

// ===== bench/prcd_src.sv
// Model of the reset configuration source and straps
module prcd_src
  import prcd_pkg::*;
(
  input wire prcd_pkg::prcd_cfg_t want,
  output prcd_pkg::prcd_cfg_t cfg_pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pins follow the bench; it only breaks codes on purpose
  assign cfg_pins = want;
endmodule : prcd_src

// ===== bench/prcd_top_tb_top.sv
// Testbench top for the PLL ratio configuration decoder
module prcd_top_tb_top;
  import prcd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  prcd_cfg_t want = '0;
  prcd_cfg_t cfg_in;
  prcd_dec_t dec_out;
  logic dec_valid;
  int err_total = 0;
  int n_checks = 0;
  localparam logic [6:0] CORES [11] = '{7'h00, 7'h43, 7'h04, 7'h05, 7'h06, 7'h07, 7'h44, 7'h45,
    7'h46, 7'h47, 7'h08};
  always #5 sys_clk = ~sys_clk;
  prcd_src i_prcd_src (.want(want), .cfg_pins(cfg_in));
  prcd_top i_prcd_top (.sys_clk(sys_clk), .rstn(rstn), .cfg_in(cfg_in), .dec_out(dec_out),
    .dec_valid(dec_valid));
  // ==========================================================
  // Expected decode
  function automatic prcd_dec_t exp_f(input prcd_cfg_t c);
    prcd_dec_t e;
    logic [6:0] r;
    logic [3:0] m;
    e = '0;
    r = c.processor_pll_ratio;
    m = c.system_pll_multiplier;
    e.ref_sel_agent = !c.host_mode;
    e.csb_multiplier = m == 4'h0 ? 5'h10 : m == 4'h1 ? 5'h00 : {1'b0, m};
    e.svco_divide = c.system_vco_divider == 2'h0 ? 4'h4 : c.system_vco_divider == 2'h1 ? 4'h8 :
      c.system_vco_divider == 2'h2 ? 4'h2 : 4'h0;
    if (r[5:2] == 4'h0)
      e.core_mode = PRCD_CORE_BYPASS;
    else if (r[5:2] == 4'h1)
    begin
      e.core_mode = r[6] ? PRCD_CORE_3TO2 : PRCD_CORE_1TO1;
      e.core_vco_divide = r[1:0] == 2'h0 ? 4'h2 : r[1:0] == 2'h1 ? 4'h4 : 4'h8;
      e.core_pll_enable = 1'b1;
      // 1.5:1 with code 11 is flagged but keeps the PLL and divide 8
      if (r == 7'h47)
        e.core_mode = PRCD_CORE_RSVD;
    end
    else
      e.core_mode = PRCD_CORE_RSVD;
    e.cfg_error = c.system_vco_divider == 2'h3 || m == 4'h1 || e.core_mode == PRCD_CORE_RSVD ||
      c.host_mode != c.input_clock_divide_strap;
    return e;
  endfunction : exp_f
  task automatic chk(input prcd_dec_t g, input prcd_dec_t e);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic chk_v(input logic g, input logic e);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_v
  // ==========================================================
  // One reset, capture and hold sequence
  task automatic run(input prcd_cfg_t c);
    int n;
    @(posedge sys_clk);
    rstn <= 1'b0;
    want <= c;
    @(posedge sys_clk);
    #1;
    chk(dec_out, '0);
    chk_v(dec_valid, 1'b0);
    @(posedge sys_clk);
    rstn <= 1'b1;
    n = 0;
    while (dec_valid !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk_v(dec_valid, 1'b1);
    chk(dec_out, exp_f(c));
    @(posedge sys_clk);
    want <= ~c;
    repeat (6) @(posedge sys_clk);
    #1;
    chk(dec_out, exp_f(c));
    chk_v(dec_valid, 1'b1);
  endtask : run
  task automatic results();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  initial
  begin
    logic [3:0] i;
    // Host cases drive the strap high, agent cases low
    for (i = 4'h0; i < 4'hb; i++)
      run({i[0], i[0], i, i[1:0], CORES[i]});
    results();
  end
  initial
  begin
    #20us;
    err_total++;
    results();
  end
endmodule : prcd_top_tb_top
bind prcd_top prcd_sva i_prcd_sva (.sys_clk(sys_clk), .rstn(rstn), .cfg_in(cfg_in),
  .dec_out(dec_out), .dec_valid(dec_valid));
